//--- hw/dtc_timer.sv
// Dual 8051-style timer/counter with AXI4-Lite registers and interrupt.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer
  import dtc_pkg::*;
(
  input wire logic sys_clk, // 20 MHz clock
  input wire logic reset, // Synchronous active-high reset
  input wire logic [4:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [4:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic countInputUnit0, // External count input, unit 0
  input wire logic countInputUnit1, // External count input, unit 1
  input wire logic gatePinUnit0, // External gate pin, unit 0
  input wire logic gatePinUnit1, // External gate pin, unit 1
  input wire logic ovfAckUnit0, // Interrupt serviced pulse, unit 0
  input wire logic ovfAckUnit1, // Interrupt serviced pulse, unit 1
  output logic irq // Level interrupt
);
  logic [7:0] timerModeSelect;
  logic [7:0] timerRunAndFlags;
  logic [7:0] lowByteUnit0;
  logic [7:0] highByteUnit0;
  logic [7:0] lowByteUnit1;
  logic [7:0] highByteUnit1;
  logic [1:0] intStatus;
  logic [1:0] intMask;
  logic [3:0] prescale;
  logic mcTick;
  logic [1:0] cntSample;
  logic [1:0] cntPrev;
  logic [1:0] cntFall;
  logic [1:0] ovf;
  logic [1:0] unitRun;
  logic [1:0] unitGateOk;
  logic [1:0] unitStep;
  logic splitHighStep;
  dtc_mode_e modeUnit0;
  dtc_mode_e modeUnit1;
  dtc_wstate_e wState;
  logic [4:0] wAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic awHeld;
  logic wHeld;
  logic wrDo;
  logic [7:0] wByte;
  logic next_ovf0;
  logic next_ovf1;
  logic [7:0] next_tl0;
  logic [7:0] next_th0;
  logic [7:0] next_tl1;
  logic [7:0] next_th1;

  assign modeUnit0 = dtc_mode_e'(timerModeSelect[1:0]);
  assign modeUnit1 = dtc_mode_e'(timerModeSelect[5:4]);

  // Machine cycle enable: one pulse every twelve system clocks.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      prescale <= 4'h0;
    else if (mcTick)
      prescale <= 4'h0;
    else
      prescale <= prescale + 4'h1;
  end
  assign mcTick = (prescale == `DTC_CLOCKS_PER_MC - 4'd1);

  // Count inputs are sampled once per machine cycle, and a fall is seen only when one
  // sample is high and the next low, so recognition spans two machine cycles and each
  // level must be held a full machine cycle by the source.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cntSample <= 2'b00;
      cntPrev <= 2'b00;
    end
    else if (mcTick)
    begin
      cntSample <= {countInputUnit1, countInputUnit0};
      cntPrev <= cntSample;
    end
  end

  // The fall becomes a count at the next machine-cycle tick.
  assign cntFall = cntPrev & ~cntSample;

  generate
    for (genvar u = 0; u < 2; u++)
    begin : g_unit
      localparam int RUNBIT = (u == 0) ? `DTC_CTRL_TR0 : `DTC_CTRL_TR1;
      localparam int GATEBIT = (u == 0) ? `DTC_MODE_GATE0 : `DTC_MODE_GATE1;
      localparam int CTBIT = (u == 0) ? `DTC_MODE_CT0 : `DTC_MODE_CT1;
      logic gatePin;
      assign gatePin = (u == 0) ? gatePinUnit0 : gatePinUnit1;
      assign unitRun[u] = timerRunAndFlags[RUNBIT];
      assign unitGateOk[u] = ~timerModeSelect[GATEBIT] | gatePin;
      assign unitStep[u] = mcTick & unitRun[u] & unitGateOk[u] &
        (timerModeSelect[CTBIT] ? cntFall[u] : 1'b1);
    end
  endgenerate

  // In split mode the high byte of unit 0 runs on unit 1's run bit as a timer.
  assign splitHighStep = mcTick & unitRun[1];

  // Unit 0 next state.
  always_comb
  begin
    next_tl0 = lowByteUnit0;
    next_th0 = highByteUnit0;
    next_ovf0 = 1'b0;
    next_ovf1 = 1'b0;
    case (modeUnit0)
      DTC_M13:
      begin
        if (unitStep[0])
        begin
          {next_ovf0, next_th0, next_tl0[4:0]} = {1'b0, highByteUnit0, lowByteUnit0[4:0]}
            + 14'h0001;
        end
        next_tl0[7:5] = 3'h0;
      end
      DTC_M16:
      begin
        if (unitStep[0])
          {next_ovf0, next_th0, next_tl0} = {1'b0, highByteUnit0, lowByteUnit0}
            + 17'h00001;
      end
      DTC_M8R:
      begin
        if (unitStep[0])
        begin
          next_ovf0 = (lowByteUnit0 == 8'hff);
          next_tl0 = next_ovf0 ? highByteUnit0 : lowByteUnit0 + 8'h01;
        end
      end
      DTC_MSPLIT:
      begin
        if (unitStep[0])
          {next_ovf0, next_tl0} = {1'b0, lowByteUnit0} + 9'h001;
        if (splitHighStep)
          {next_ovf1, next_th0} = {1'b0, highByteUnit0} + 9'h001;
      end
      default:
      begin
        next_tl0 = lowByteUnit0;
      end
    endcase
  end

  // Unit 1 next state; it never raises its flag while unit 0 is split.
  always_comb
  begin
    next_tl1 = lowByteUnit1;
    next_th1 = highByteUnit1;
    ovf = {next_ovf1, next_ovf0};
    case (modeUnit1)
      DTC_M13:
      begin
        if (unitStep[1])
        begin
          {ovf[1], next_th1, next_tl1[4:0]} = {1'b0, highByteUnit1, lowByteUnit1[4:0]}
            + 14'h0001;
        end
        next_tl1[7:5] = 3'h0;
      end
      DTC_M16:
      begin
        if (unitStep[1])
          {ovf[1], next_th1, next_tl1} = {1'b0, highByteUnit1, lowByteUnit1}
            + 17'h00001;
      end
      DTC_M8R:
      begin
        if (unitStep[1])
        begin
          ovf[1] = (lowByteUnit1 == 8'hff);
          next_tl1 = ovf[1] ? highByteUnit1 : lowByteUnit1 + 8'h01;
        end
      end
      DTC_MSPLIT:
      begin
        next_tl1 = lowByteUnit1;
      end
      default:
      begin
        next_tl1 = lowByteUnit1;
      end
    endcase
    if (modeUnit0 == DTC_MSPLIT)
      ovf[1] = next_ovf1;
  end

  // Write channel: address and data may arrive in either order.
  assign s_axi_awready = (wState == DTC_WIDLE) & ~awHeld;
  assign s_axi_wready = (wState == DTC_WIDLE) & ~wHeld;
  assign wrDo = (wState == DTC_WIDLE) & awHeld & wHeld;
  assign wByte = wStrb[0] ? wData[7:0] : 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wState <= DTC_WIDLE;
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wAddr <= 5'h00;
      wData <= 32'h0;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `DTC_RESP_OKAY;
    end
    else
    begin
      case (wState)
        DTC_WIDLE:
        begin
          if (s_axi_awvalid & s_axi_awready)
          begin
            awHeld <= 1'b1;
            wAddr <= s_axi_awaddr;
          end
          if (s_axi_wvalid & s_axi_wready)
          begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
          end
          if (wrDo)
          begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wAddr[1:0] != 2'b00) ? `DTC_RESP_SLVERR : `DTC_RESP_OKAY;
            wState <= DTC_WRESP;
          end
        end
        DTC_WRESP:
        begin
          if (s_axi_bready)
          begin
            s_axi_bvalid <= 1'b0;
            wState <= DTC_WIDLE;
          end
        end
        default:
        begin
          wState <= DTC_WIDLE;
        end
      endcase
    end
  end

  // Mode register.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      timerModeSelect <= `DTC_MODE_RESET;
    else if (wrDo && wAddr == `DTC_ADDR_MODE && wStrb[0])
      timerModeSelect <= wByte;
  end

  // Control register; hardware sets of the overflow flags win over software clears.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      timerRunAndFlags <= `DTC_CTRL_RESET;
    else
    begin
      if (wrDo && wAddr == `DTC_ADDR_CTRL && wStrb[0])
        timerRunAndFlags <= wByte;
      if (ovfAckUnit0)
        timerRunAndFlags[`DTC_CTRL_TF0] <= 1'b0;
      if (ovfAckUnit1)
        timerRunAndFlags[`DTC_CTRL_TF1] <= 1'b0;
      if (ovf[0])
        timerRunAndFlags[`DTC_CTRL_TF0] <= 1'b1;
      if (ovf[1])
        timerRunAndFlags[`DTC_CTRL_TF1] <= 1'b1;
    end
  end

  // Count registers; a software write takes effect over the counting step.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      lowByteUnit0 <= 8'h00;
      highByteUnit0 <= 8'h00;
      lowByteUnit1 <= 8'h00;
      highByteUnit1 <= 8'h00;
    end
    else
    begin
      lowByteUnit0 <= next_tl0;
      highByteUnit0 <= next_th0;
      lowByteUnit1 <= next_tl1;
      highByteUnit1 <= next_th1;
      if (wrDo && wStrb[0])
      begin
        case (wAddr)
          `DTC_ADDR_TL0: lowByteUnit0 <= wByte;
          `DTC_ADDR_TH0: highByteUnit0 <= wByte;
          `DTC_ADDR_TL1: lowByteUnit1 <= wByte;
          `DTC_ADDR_TH1: highByteUnit1 <= wByte;
          default: lowByteUnit0 <= next_tl0;
        endcase
      end
    end
  end

  // Interrupt status is sticky, write one to clear, and a new event wins.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      intStatus <= 2'b00;
      intMask <= 2'b00;
    end
    else
    begin
      if (wrDo && wAddr == `DTC_ADDR_IMASK && wStrb[0])
        intMask <= wData[1:0];
      if (wrDo && wAddr == `DTC_ADDR_ISTAT && wStrb[0])
        intStatus <= (intStatus & ~wData[1:0]) | ovf;
      else
        intStatus <= intStatus | ovf;
    end
  end
  assign irq = |(intStatus & intMask);

  // Read channel: one cycle to answer, held until accepted.
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `DTC_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `DTC_RESP_OKAY;
      case (s_axi_araddr)
        `DTC_ADDR_MODE: s_axi_rdata <= {24'h0, timerModeSelect};
        `DTC_ADDR_CTRL: s_axi_rdata <= {24'h0, timerRunAndFlags};
        `DTC_ADDR_TL0: s_axi_rdata <= {24'h0, lowByteUnit0};
        `DTC_ADDR_TH0: s_axi_rdata <= {24'h0, highByteUnit0};
        `DTC_ADDR_TL1: s_axi_rdata <= {24'h0, lowByteUnit1};
        `DTC_ADDR_TH1: s_axi_rdata <= {24'h0, highByteUnit1};
        `DTC_ADDR_ISTAT: s_axi_rdata <= {30'h0, intStatus};
        `DTC_ADDR_IMASK: s_axi_rdata <= {30'h0, intMask};
        default:
        begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `DTC_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // dtc_timer

//--- pkg/dtc_cfg.svh
// Register offsets, field positions and timing counts for the dual timer counter.
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_ADDR_MODE 5'h00
`define DTC_ADDR_CTRL 5'h04
`define DTC_ADDR_TL0 5'h08
`define DTC_ADDR_TH0 5'h0c
`define DTC_ADDR_TL1 5'h10
`define DTC_ADDR_TH1 5'h14
`define DTC_ADDR_ISTAT 5'h18
`define DTC_ADDR_IMASK 5'h1c
`define DTC_MODE_RESET 8'h00
`define DTC_CTRL_RESET 8'h00
`define DTC_CTRL_TF1 7
`define DTC_CTRL_TR1 6
`define DTC_CTRL_TF0 5
`define DTC_CTRL_TR0 4
`define DTC_CTRL_IE1 3
`define DTC_CTRL_IT1 2
`define DTC_CTRL_IE0 1
`define DTC_CTRL_IT0 0
`define DTC_MODE_GATE1 7
`define DTC_MODE_CT1 6
`define DTC_MODE_GATE0 3
`define DTC_MODE_CT0 2
`define DTC_CLOCKS_PER_MC 4'd12
`define DTC_RESP_OKAY 2'b00
`define DTC_RESP_SLVERR 2'b10
`endif

//--- pkg/dtc_pkg.sv
// Types for the dual timer counter.
package dtc_pkg;
  typedef enum logic [1:0]
  {
    DTC_M13 = 2'b00,
    DTC_M16 = 2'b01,
    DTC_M8R = 2'b10,
    DTC_MSPLIT = 2'b11
  } dtc_mode_e;
  typedef enum logic [1:0]
  {
    DTC_WIDLE = 2'b01,
    DTC_WRESP = 2'b10
  } dtc_wstate_e;
endpackage

//--- verification/dtc_pin_model.sv
// Model of the external count inputs and gate pins.
`timescale 1ns/1ps
module dtc_pin_model
(
  input wire logic sys_clk, // Clock
  output logic countInputUnit0, // Count input, unit 0
  output logic countInputUnit1, // Count input, unit 1
  output logic gatePinUnit0, // Gate pin, unit 0
  output logic gatePinUnit1 // Gate pin, unit 1
);
  initial
  begin
    countInputUnit0 = 1'h1;
    countInputUnit1 = 1'h1;
    gatePinUnit0 = 1'h0;
    gatePinUnit1 = 1'h0;
  end
  // Each level is held hold clocks; below twelve the edge may be missed.
  task automatic pulses(input int unit, input int n, input int hold);
    for (int i = 0; i < 2 * n; i++)
    begin
      @(posedge sys_clk);
      if (unit == 0) countInputUnit0 <= ~countInputUnit0;
      else countInputUnit1 <= ~countInputUnit1;
      repeat (hold - 1) @(posedge sys_clk);
    end
  endtask
  task automatic gate(input logic g0, input logic g1);
    @(posedge sys_clk);
    gatePinUnit0 <= g0;
    gatePinUnit1 <= g1;
  endtask
endmodule // dtc_pin_model

//--- verification/dtc_timer_monitor.sv
// Bus and interrupt assertions for the dual timer counter.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer_monitor
(
  input wire logic sys_clk, // Clock
  input wire logic reset, // Reset
  input wire logic [4:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Address valid
  input wire logic s_axi_awready, // Address ready
  input wire logic s_axi_wvalid, // Data valid
  input wire logic s_axi_wready, // Data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic [4:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read valid
  input wire logic s_axi_arready, // Read ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_write_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (s_write_taken |=> s_write_answer)
    else $error("write response not on time");
  a_bad_write: assert property (s_write_taken and s_axi_awaddr[1:0] != 2'h0
    |=> ##1 s_axi_bresp == `DTC_RESP_SLVERR) else $error("unaligned write not refused");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_ready: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[1:0] != 2'h0
    |=> s_axi_rresp == `DTC_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
  // Only a register write may clear or mask a pending overflow.
  a_irq_clear: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("interrupt dropped without a write");
endmodule // dtc_timer_monitor
bind dtc_timer dtc_timer_monitor u_dtc_timer_monitor (.sys_clk, .reset, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .irq);

//--- verification/dtc_timer_tb.sv
// Self-checking testbench for the dual timer counter.
`timescale 1ns/1ps
`include "dtc_cfg.svh"
module dtc_timer_tb;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ovfAckUnit0 = 1'h0, ovfAckUnit1 = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic countInputUnit0, countInputUnit1, gatePinUnit0, gatePinUnit1;
  int n_fail = 0;
  int compares = 0;
  always #25 sys_clk = ~sys_clk;
  dtc_timer u_dtc_timer (.sys_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .countInputUnit0, .countInputUnit1, .gatePinUnit0,
    .gatePinUnit1, .ovfAckUnit0, .ovfAckUnit1, .irq);
  dtc_pin_model u_dtc_pin_model (.sys_clk, .countInputUnit0, .countInputUnit1, .gatePinUnit0,
    .gatePinUnit1);
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic stuck();
    n_fail++;
    $display("wrong value at %0t: wait ran out", $time);
    end_of_test();
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (n > 50) stuck();
    end
    while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic w(input logic [4:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (n > 50) stuck();
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(d, exp);
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (n > 400) stuck();
    end
    while (irq !== 1'h1);
  endtask
  task automatic ack(input logic unit);
    @(posedge sys_clk);
    if (unit) ovfAckUnit1 <= 1'h1;
    else ovfAckUnit0 <= 1'h1;
    @(posedge sys_clk);
    ovfAckUnit0 <= 1'h0;
    ovfAckUnit1 <= 1'h0;
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rc(`DTC_ADDR_MODE, 32'h0);
    rc(`DTC_ADDR_CTRL, 32'h0);
    w(`DTC_ADDR_CTRL, 32'h0f);
    rc(`DTC_ADDR_CTRL, 32'h0f);
    rd(5'h02, d, r);
    check({30'h0, r}, {30'h0, `DTC_RESP_SLVERR});
    wr(5'h01, 32'hff, r);
    check({30'h0, r}, {30'h0, `DTC_RESP_SLVERR});
    rc(`DTC_ADDR_MODE, 32'h0);
    w(`DTC_ADDR_CTRL, 32'h0);
    w(`DTC_ADDR_IMASK, 32'h3);
    $display("register test done");
  endtask
  task automatic t_timer16();
    int n;
    logic [31:0] d;
    logic [1:0] r;
    // Mode 01 goes first: in mode 00 the top three low-byte bits would be cleared.
    w(`DTC_ADDR_MODE, 32'h01);
    w(`DTC_ADDR_TL0, 32'hfe);
    w(`DTC_ADDR_TH0, 32'hff);
    w(`DTC_ADDR_CTRL, 32'h10);
    wait_irq(n);
    // Two machine cycles are needed; the first may come at any phase.
    check({31'h0, n >= 11 && n <= 26}, 32'h1);
    rc(`DTC_ADDR_CTRL, 32'h30);
    rc(`DTC_ADDR_ISTAT, 32'h1);
    rc(`DTC_ADDR_TH0, 32'h0);
    ack(1'h0);
    rc(`DTC_ADDR_CTRL, 32'h10);
    w(`DTC_ADDR_ISTAT, 32'h1);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    w(`DTC_ADDR_CTRL, 32'h0);
    rd(`DTC_ADDR_TL0, d, r);
    repeat (30) @(posedge sys_clk);
    rc(`DTC_ADDR_TL0, d);
    $display("16-bit timer test done");
  endtask
  task automatic t_mode13();
    int n;
    w(`DTC_ADDR_MODE, 32'h00);
    w(`DTC_ADDR_TL0, 32'hff);
    rc(`DTC_ADDR_TL0, 32'h1f);
    w(`DTC_ADDR_TH0, 32'hff);
    w(`DTC_ADDR_CTRL, 32'h10);
    wait_irq(n);
    w(`DTC_ADDR_CTRL, 32'h0);
    rc(`DTC_ADDR_TH0, 32'h0);
    w(`DTC_ADDR_IMASK, 32'h0);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h0);
    w(`DTC_ADDR_IMASK, 32'h3);
    @(posedge sys_clk);
    check({31'h0, irq}, 32'h1);
    w(`DTC_ADDR_ISTAT, 32'h1);
    $display("13-bit timer test done");
  endtask
  task automatic t_reload();
    int n;
    logic [31:0] d;
    logic [1:0] r;
    w(`DTC_ADDR_MODE, 32'h20);
    w(`DTC_ADDR_TH1, 32'h80);
    w(`DTC_ADDR_TL1, 32'hfe);
    w(`DTC_ADDR_CTRL, 32'h40);
    wait_irq(n);
    w(`DTC_ADDR_CTRL, 32'h0);
    rc(`DTC_ADDR_TH1, 32'h80);
    rd(`DTC_ADDR_TL1, d, r);
    check({31'h0, d == 32'h80 || d == 32'h81}, 32'h1);
    rc(`DTC_ADDR_ISTAT, 32'h2);
    w(`DTC_ADDR_ISTAT, 32'h2);
    $display("auto-reload test done");
  endtask
  task automatic t_count();
    w(`DTC_ADDR_MODE, 32'h55);
    w(`DTC_ADDR_TL0, 32'h0);
    w(`DTC_ADDR_TL1, 32'h0);
    w(`DTC_ADDR_CTRL, 32'h50);
    u_dtc_pin_model.pulses(0, 5, 13);
    u_dtc_pin_model.pulses(1, 4, 13);
    repeat (30) @(posedge sys_clk);
    rc(`DTC_ADDR_TL0, 32'h5);
    rc(`DTC_ADDR_TL1, 32'h4);
    w(`DTC_ADDR_MODE, 32'h0d);
    u_dtc_pin_model.pulses(0, 3, 13);
    repeat (30) @(posedge sys_clk);
    rc(`DTC_ADDR_TL0, 32'h5);
    u_dtc_pin_model.gate(1'h1, 1'h0);
    u_dtc_pin_model.pulses(0, 2, 13);
    repeat (30) @(posedge sys_clk);
    w(`DTC_ADDR_CTRL, 32'h0);
    rc(`DTC_ADDR_TL0, 32'h7);
    $display("counter test done");
  endtask
  task automatic t_split();
    int n;
    w(`DTC_ADDR_MODE, 32'h33);
    w(`DTC_ADDR_TL0, 32'h0);
    w(`DTC_ADDR_TH0, 32'hfe);
    w(`DTC_ADDR_TL1, 32'h55);
    w(`DTC_ADDR_CTRL, 32'h40);
    wait_irq(n);
    rc(`DTC_ADDR_CTRL, 32'hc0);
    ack(1'h1);
    rc(`DTC_ADDR_CTRL, 32'h40);
    w(`DTC_ADDR_CTRL, 32'h0);
    rc(`DTC_ADDR_TL0, 32'h0);
    rc(`DTC_ADDR_TL1, 32'h55);
    rc(`DTC_ADDR_ISTAT, 32'h2);
    $display("split mode test done");
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    reset <= 1'h0;
    t_regs();
    t_timer16();
    t_mode13();
    t_reload();
    t_count();
    t_split();
    end_of_test();
  end
endmodule // dtc_timer_tb
